// ===== design/adcif_defines.svh
// constants for the adc command decoder: commands, fields, reset values, frame layout
`ifndef ADCIF_DEFINES_SVH
`define ADCIF_DEFINES_SVH

// ---------------------------------------------------------------
// command byte patterns (? bits are don't care)
// ---------------------------------------------------------------
`define ADCIF_CMD_RESET     8'b0000_011?
`define ADCIF_CMD_START     8'b0000_100?
`define ADCIF_CMD_SLEEP     8'b0000_001?
`define ADCIF_CMD_RDATA     8'b0001_????
`define ADCIF_CMD_RCFG      8'b0010_????
`define ADCIF_CMD_WCFG      8'b0100_????
`define ADCIF_IDX_HI        3
`define ADCIF_IDX_LO        2

// ---------------------------------------------------------------
// configuration registers
// ---------------------------------------------------------------
`define ADCIF_REG_INPUT     2'h0
`define ADCIF_REG_RATE      2'h1
`define ADCIF_REG_STATUS    2'h2
`define ADCIF_REG_ROUTE     2'h3
`define ADCIF_CFG_RESET     8'h00
`define ADCIF_CONT_BIT      3
`define ADCIF_READY_BIT     7
`define ADCIF_CNTEN_BIT     6
`define ADCIF_INTEG_HI      5
`define ADCIF_INTEG_LO      4
`define ADCIF_STATUS_WMASK  8'h7f
`define ADCIF_ROUTE_WMASK   8'hfc
`define ADCIF_INTEG_NONE    2'h0
`define ADCIF_INTEG_INV     2'h1

// ---------------------------------------------------------------
// integrity word and frame layout
// ---------------------------------------------------------------
`define ADCIF_CRC_INIT      16'hffff
`define ADCIF_CRC_POLY      16'h1021
`define ADCIF_FRAME_DEPTH   8
`define ADCIF_BASE_DEPTH    4
`define ADCIF_IDLE_BYTE     8'hff
`define ADCIF_BIT_LAST      4'h7
`define ADCIF_BIT_FIRST     4'h0
// address byte also counts the clock fall that ends the start condition
`define ADCIF_ADDR_LAST     4'h8

`endif

// ===== design/adcif_pkg.sv
// types shared by the adc command decoder
package adcif_pkg;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ADDR_ACK,
    BUS_WRITE,
    BUS_WRITE_ACK,
    BUS_READ,
    BUS_READ_ACK
  } adcif_bus_t;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_RUN,
    CONV_SLEEP
  } adcif_conv_t;

endpackage

// ===== design/adcif_decoder.sv
// two-wire target, command decoder, config registers and result framing for the adc
`timescale 1ns/1ps
`include "adcif_defines.svh"

module adcif_decoder #(
  parameter logic [6:0] TARGET_ADDR = 7'h40,
  parameter int         RESULT_W    = 24
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                sclIn,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOe,
  output logic                     readyPinOut,
  output logic                     readyPinOe,
  input  wire logic                convDone,
  input  wire logic [RESULT_W-1:0] convResult,
  output logic                     convStart,
  output logic                     analogOn,
  output logic [7:0]               inputConfig,
  output logic [7:0]               rateConfig,
  output logic [7:0]               statusConfig,
  output logic [7:0]               routeConfig
);

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic sclS1_reg, sclS2_reg, sclPrev_reg;
  logic sdaS1_reg, sdaS2_reg, sdaPrev_reg;

  always_ff @(posedge clock)
  begin
    sclS1_reg   <= sclIn;
    sclS2_reg   <= sclS1_reg;
    sclPrev_reg <= sclS2_reg;
    sdaS1_reg   <= sdaIn;
    sdaS2_reg   <= sdaS1_reg;
    sdaPrev_reg <= sdaS2_reg;
  end

  logic sclRise, sclFall, startDet, stopDet;
  assign sclRise  = sclS2_reg & ~sclPrev_reg;
  assign sclFall  = ~sclS2_reg & sclPrev_reg;
  assign startDet = sclS2_reg & sclPrev_reg & sdaPrev_reg & ~sdaS2_reg;
  assign stopDet  = sclS2_reg & sclPrev_reg & ~sdaPrev_reg & sdaS2_reg;

  // ---------------------------------------------------------------
  // shared state
  // ---------------------------------------------------------------
  adcif_pkg::adcif_bus_t  busState_reg;
  adcif_pkg::adcif_conv_t convState_reg;
  logic [3:0]             bitCnt_reg;
  logic [7:0]             rxShift_reg;
  logic [7:0]             txShift_reg;
  logic [2:0]             txIdx_reg;
  logic                   isRead_reg;
  logic                   masterNack_reg;
  logic                   rxValid_reg;
  logic [7:0]             rxByte_reg;
  logic [7:0]             txBuf_reg [0:`ADCIF_FRAME_DEPTH-1];
  logic [7:0]             cfg_reg [0:3];
  logic                   writePending_reg;
  logic [1:0]             writeIdx_reg;
  logic                   readyFlag_reg;
  logic [7:0]             convCount_reg;
  logic [RESULT_W-1:0]    latest_reg;
  logic                   sleepPending_reg;
  logic                   startReq, sleepReq, writeReq, softRst, readDataCmd, readCfgCmd;
  logic [1:0]             cmdIdx;

  // ---------------------------------------------------------------
  // two-wire target engine
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    rxValid_reg <= 1'b0;
    if (rst) // reset command deliberately leaves the engine alone so acks go out
    begin
      busState_reg   <= adcif_pkg::BUS_IDLE;
      bitCnt_reg     <= `ADCIF_BIT_FIRST;
      rxShift_reg    <= `ADCIF_CFG_RESET;
      txShift_reg    <= `ADCIF_IDLE_BYTE;
      txIdx_reg      <= 3'h0;
      isRead_reg     <= 1'b0;
      masterNack_reg <= 1'b0;
      rxByte_reg     <= `ADCIF_CFG_RESET;
      sdaOe          <= 1'b0;
    end
    else if (startDet)
    begin
      busState_reg <= adcif_pkg::BUS_ADDR;
      bitCnt_reg   <= `ADCIF_BIT_FIRST;
      sdaOe        <= 1'b0;
    end
    else if (stopDet)
    begin
      busState_reg <= adcif_pkg::BUS_IDLE;
      sdaOe        <= 1'b0;
    end
    else if (sclRise)
    begin
      rxShift_reg    <= {rxShift_reg[6:0], sdaS2_reg};
      masterNack_reg <= sdaS2_reg;
    end
    else if (sclFall)
    begin
      unique case (busState_reg)
        adcif_pkg::BUS_IDLE: ;
        adcif_pkg::BUS_ADDR:
          if (bitCnt_reg != `ADCIF_ADDR_LAST) // start's own fall is counted too
            bitCnt_reg <= bitCnt_reg + 4'h1;
          else if (rxShift_reg[7:1] == TARGET_ADDR)
          begin
            isRead_reg   <= rxShift_reg[0];
            sdaOe        <= 1'b1;
            busState_reg <= adcif_pkg::BUS_ADDR_ACK;
          end
          else
            busState_reg <= adcif_pkg::BUS_IDLE;
        adcif_pkg::BUS_ADDR_ACK, adcif_pkg::BUS_READ_ACK:
        begin
          bitCnt_reg <= `ADCIF_BIT_FIRST;
          if (busState_reg == adcif_pkg::BUS_READ_ACK && masterNack_reg)
          begin
            sdaOe        <= 1'b0;
            busState_reg <= adcif_pkg::BUS_IDLE;
          end
          else if (isRead_reg) // bytes come from the frame buffer only
          begin
            txShift_reg  <= txBuf_reg[txIdx_reg];
            sdaOe        <= ~txBuf_reg[txIdx_reg][7];
            txIdx_reg    <= txIdx_reg + 3'h1;
            busState_reg <= adcif_pkg::BUS_READ;
          end
          else
          begin
            sdaOe        <= 1'b0;
            busState_reg <= adcif_pkg::BUS_WRITE;
          end
        end
        adcif_pkg::BUS_WRITE:
          if (bitCnt_reg != `ADCIF_BIT_LAST)
            bitCnt_reg <= bitCnt_reg + 4'h1;
          else
          begin
            rxValid_reg  <= 1'b1; // byte captured on the eighth fall
            rxByte_reg   <= rxShift_reg;
            sdaOe        <= 1'b1;
            busState_reg <= adcif_pkg::BUS_WRITE_ACK;
          end
        adcif_pkg::BUS_WRITE_ACK:
        begin
          bitCnt_reg   <= `ADCIF_BIT_FIRST;
          sdaOe        <= 1'b0;
          busState_reg <= adcif_pkg::BUS_WRITE;
        end
        adcif_pkg::BUS_READ:
          if (bitCnt_reg != `ADCIF_BIT_LAST)
          begin
            bitCnt_reg  <= bitCnt_reg + 4'h1;
            txShift_reg <= {txShift_reg[6:0], 1'b1};
            sdaOe       <= ~txShift_reg[6];
          end
          else
          begin
            sdaOe        <= 1'b0;
            busState_reg <= adcif_pkg::BUS_READ_ACK;
          end
      endcase
    end
    if (!rst && rxValid_reg && (readDataCmd || readCfgCmd))
      txIdx_reg <= 3'h0;
  end

  always_ff @(posedge clock)
  begin
    sdaOut      <= 1'b0;
    readyPinOut <= 1'b0;
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  always_comb
  begin
    startReq    = 1'b0;
    sleepReq    = 1'b0;
    softRst     = 1'b0;
    readDataCmd = 1'b0;
    readCfgCmd  = 1'b0;
    writeReq    = rxValid_reg & writePending_reg;
    cmdIdx      = rxByte_reg[`ADCIF_IDX_HI:`ADCIF_IDX_LO];
    if (rxValid_reg && !writePending_reg)
    begin
      casez (rxByte_reg)
        `ADCIF_CMD_RESET: softRst     = 1'b1;
        `ADCIF_CMD_START: startReq    = 1'b1;
        `ADCIF_CMD_SLEEP: sleepReq    = 1'b1;
        `ADCIF_CMD_RDATA: readDataCmd = 1'b1;
        `ADCIF_CMD_RCFG:  readCfgCmd  = 1'b1;
        default: ; // anything else raises no request here; a write-config byte only sets the pending write below
      endcase
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst || softRst || startDet)
      writePending_reg <= 1'b0;
    else if (rxValid_reg)
      writePending_reg <= !writePending_reg && (rxByte_reg ==? `ADCIF_CMD_WCFG);
    if (rxValid_reg && !writePending_reg)
      writeIdx_reg <= cmdIdx;
    if (rst || softRst) // zero at reset, untouched by sleep
      for (int i = 0; i < 4; i++)
        cfg_reg[i] <= `ADCIF_CFG_RESET;
    else if (writeReq) // only path that writes a register
      unique case (writeIdx_reg)
        `ADCIF_REG_STATUS: cfg_reg[2] <= rxByte_reg & `ADCIF_STATUS_WMASK;
        `ADCIF_REG_ROUTE:  cfg_reg[3] <= rxByte_reg & `ADCIF_ROUTE_WMASK;
        default:           cfg_reg[writeIdx_reg] <= rxByte_reg;
      endcase
  end

  assign inputConfig  = cfg_reg[0];
  assign rateConfig   = cfg_reg[1];
  assign routeConfig  = cfg_reg[3];
  always_ff @(posedge clock)
    statusConfig <= cfg_reg[2];

  // ---------------------------------------------------------------
  // result, counter and ready flag
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst || softRst)
    begin
      readyFlag_reg <= 1'b0;
      convCount_reg <= 8'h00;
      latest_reg    <= '0;
    end
    else
    begin
      if (convDone) // set beats the clear of a same-cycle read-data
        readyFlag_reg <= 1'b1;
      else if (readDataCmd)
        readyFlag_reg <= 1'b0;
      if (convDone)
      begin
        latest_reg    <= convResult;
        convCount_reg <= convCount_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clock)
    readyPinOe <= readyFlag_reg;

  // ---------------------------------------------------------------
  // frame builder: data or register, then integrity words
  // ---------------------------------------------------------------
  logic [7:0]  base [0:`ADCIF_BASE_DEPTH-1];
  logic [7:0]  frame [0:`ADCIF_FRAME_DEPTH-1];
  logic [2:0]  baseLen;
  logic [15:0] crc;
  logic [1:0]  integ;

  always_comb
  begin
    integ = cfg_reg[2][`ADCIF_INTEG_HI:`ADCIF_INTEG_LO];
    crc   = `ADCIF_CRC_INIT;
    for (int i = 0; i < `ADCIF_BASE_DEPTH; i++)
      base[i] = `ADCIF_CFG_RESET;
    for (int i = 0; i < `ADCIF_FRAME_DEPTH; i++)
      frame[i] = `ADCIF_IDLE_BYTE;
    if (readCfgCmd)
    begin
      base[0] = (cmdIdx == `ADCIF_REG_STATUS) ?
                {readyFlag_reg, cfg_reg[2][6:0]} : cfg_reg[cmdIdx];
      baseLen = 3'h1;
    end
    else if (cfg_reg[2][`ADCIF_CNTEN_BIT])
    begin
      base[0] = convCount_reg;
      {base[1], base[2], base[3]} = latest_reg; // msb first
      baseLen = 3'h4;
    end
    else
    begin
      {base[0], base[1], base[2]} = latest_reg;
      baseLen = 3'h3;
    end
    for (int i = 0; i < `ADCIF_BASE_DEPTH; i++)
      if (i < baseLen)
      begin
        frame[i] = base[i];
        for (int b = 7; b >= 0; b--)
          crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ base[i][b]) ? `ADCIF_CRC_POLY : 16'h0000);
        if (integ == `ADCIF_INTEG_INV) // inverted copy per data byte
          frame[baseLen + 3'(i)] = ~base[i];
      end
    if (integ[1]) // crc16 adds exactly two bytes
    begin
      frame[baseLen]        = crc[15:8];
      frame[baseLen + 3'h1] = crc[7:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst || softRst)
      for (int i = 0; i < `ADCIF_FRAME_DEPTH; i++)
        txBuf_reg[i] <= `ADCIF_IDLE_BYTE;
    else if (readDataCmd || readCfgCmd) // loaded only by a command, never by a result
      for (int i = 0; i < `ADCIF_FRAME_DEPTH; i++)
        txBuf_reg[i] <= frame[i];
  end

  // ---------------------------------------------------------------
  // conversion control
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    convStart <= 1'b0;
    if (rst || softRst)
    begin
      convState_reg    <= adcif_pkg::CONV_IDLE;
      analogOn         <= 1'b1;
      sleepPending_reg <= 1'b0;
    end
    else if (startReq) // start, or filter clear and restart
    begin
      analogOn         <= 1'b1; // wake from sleep
      convStart        <= 1'b1;
      sleepPending_reg <= 1'b0;
      convState_reg    <= adcif_pkg::CONV_RUN;
    end
    else if (writeReq && convState_reg == adcif_pkg::CONV_RUN)
      convStart <= 1'b1;
    else if (sleepReq && convState_reg == adcif_pkg::CONV_RUN)
      sleepPending_reg <= 1'b1;
    else if (sleepReq)
    begin
      analogOn      <= 1'b0;
      convState_reg <= adcif_pkg::CONV_SLEEP;
    end
    else if (convDone && convState_reg == adcif_pkg::CONV_RUN)
    begin
      if (sleepPending_reg)
      begin
        analogOn         <= 1'b0;
        sleepPending_reg <= 1'b0;
        convState_reg    <= adcif_pkg::CONV_SLEEP;
      end
      else if (!cfg_reg[1][`ADCIF_CONT_BIT])
        convState_reg <= adcif_pkg::CONV_IDLE; // one-shot ends here
    end
  end

endmodule

// ===== test/adcif_decoder_asserts.sv
// concurrent checks on the adc command decoder ports
`timescale 1ns/1ps

module adcif_checker #(
  parameter int RESULT_W = 24
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                sclIn,
  input wire logic                sdaIn,
  input wire logic                sdaOut,
  input wire logic                sdaOe,
  input wire logic                readyPinOut,
  input wire logic                readyPinOe,
  input wire logic                convDone,
  input wire logic [RESULT_W-1:0] convResult,
  input wire logic                convStart,
  input wire logic                analogOn,
  input wire logic [7:0]          inputConfig,
  input wire logic [7:0]          rateConfig,
  input wire logic [7:0]          statusConfig,
  input wire logic [7:0]          routeConfig
);
  // --------------------------------
  // age of last bus clock fall
  // --------------------------------
  logic        sclLast;
  logic [3:0]  fallAge;
  logic        recentFall;
  logic [31:0] cfgAll;

  always_ff @(posedge clock)
  begin
    sclLast <= sclIn;
  end

  // saturates so a long idle never looks recent
  always_ff @(posedge clock)
  begin
    if (rst)
      fallAge <= 4'hf;
    else if (sclLast && !sclIn)
      fallAge <= 4'h0;
    else if (fallAge != 4'hf)
      fallAge <= fallAge + 4'h1;
  end

  assign recentFall = (fallAge <= 4'h9);
  assign cfgAll = {inputConfig, rateConfig, statusConfig, routeConfig};

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // --------------------------------
  // properties
  // --------------------------------
  property p_open_drain; !readyPinOut && !sdaOut; endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin driven high");
  property p_ready_set; convDone |-> ##2 readyPinOe; endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready pin not low after result");
  property p_ready_clear; $fell(readyPinOe) |-> recentFall || $past(rst); endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready pin released idle");
  property p_start_pulse; convStart |=> !convStart; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_start_cause; convStart |-> recentFall; endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without command");
  property p_cfg_cause; $changed(cfgAll) |-> recentFall || $past(rst) || $past(rst, 2); endproperty
  a_cfg_cause: assert property (p_cfg_cause) else $error("config changed off bus");
  property p_reset_zero; $past(rst) && $past(rst, 2) |-> cfgAll == 32'h0 && analogOn && !sdaOe;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset state wrong");
  property p_sleep_cause;
    $fell(analogOn) |-> recentFall || $past(convDone) || $past(convDone, 2) || $past(convDone, 3);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without cause");
  property p_wake_cause; $rose(analogOn) |-> recentFall || $past(rst); endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without command");
  property p_sda_steady; sclIn && $past(sclIn) && $past(sclIn, 2) |-> $stable(sdaOe); endproperty
  a_sda_steady: assert property (p_sda_steady) else $error("data moved while clock high");
endmodule

// ===== test/adcif_host_model.sv
// two-wire bus host model
`timescale 1ns/1ps

module adcif_host_model (
  input  wire logic clock,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow
);
  // long low phase: target answers 2-3 clocks after a fall
  localparam int LOW_CYC  = 5;
  localparam int HIGH_CYC = 3;

  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic waitCyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic bitCycle(input logic b, output logic s);
    scl = 1'b0;
    waitCyc(2);
    sdaLow = !b;
    waitCyc(LOW_CYC - 2);
    scl = 1'b1;
    waitCyc(1);
    s = sdaLine;
    waitCyc(HIGH_CYC - 1);
  endtask

  // start or repeated start: data released with clock low, then pulled low with clock high
  task automatic startCond();
    scl = 1'b0;
    waitCyc(2);
    sdaLow = 1'b0;
    waitCyc(3);
    scl = 1'b1;
    waitCyc(3);
    sdaLow = 1'b1;
    waitCyc(3);
  endtask

  task automatic stopCond();
    scl = 1'b0;
    waitCyc(2);
    sdaLow = 1'b1;
    waitCyc(3);
    scl = 1'b1;
    waitCyc(3);
    sdaLow = 1'b0;
    waitCyc(3);
  endtask

  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitCycle(d[i], s);
    bitCycle(1'b1, ack);
  endtask

  // host acks every byte but the last
  task automatic readByte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitCycle(1'b1, d[i]);
    bitCycle(!more, s);
  endtask
endmodule

// ===== test/adcif_testbench.sv
// self-checking bench for the adc command decoder
`timescale 1ns/1ps
`include "adcif_defines.svh"

module testbench;
  localparam logic [6:0] ADDR = 7'h40;
  logic        clock;
  logic        rst;
  wire logic   sclLine;
  wire logic   hostLow;
  wire logic   sdaLine;
  logic        sdaOut;
  logic        sdaOe;
  logic        readyPinOut;
  logic        readyPinOe;
  logic        convDone;
  logic [23:0] convResult;
  logic        convStart;
  logic        analogOn;
  logic [7:0]  inputConfig;
  logic [7:0]  rateConfig;
  logic [7:0]  statusConfig;
  logic [7:0]  routeConfig;
  logic [7:0]  rx [8];
  logic        ack;
  int          failCount;
  int          nChecks;
  int          starts;
  int          s0;

  // pulled up unless a party pulls low
  assign sdaLine = !(hostLow || sdaOe);

  adcif_host_model host_u (.clock(clock), .sdaLine(sdaLine), .scl(sclLine), .sdaLow(hostLow));

  adcif_decoder #(.TARGET_ADDR(ADDR), .RESULT_W(24)) dut_u (
    .clock(clock), .rst(rst), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .readyPinOut(readyPinOut), .readyPinOe(readyPinOe), .convDone(convDone),
    .convResult(convResult), .convStart(convStart), .analogOn(analogOn),
    .inputConfig(inputConfig), .rateConfig(rateConfig), .statusConfig(statusConfig),
    .routeConfig(routeConfig));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // sampled away from the launching edge to avoid a race
  always @(negedge clock)
    if (convStart === 1'b1)
      starts++;

  task automatic finalReport();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] b [$]);
    host_u.startCond();
    host_u.writeByte({ADDR, 1'b0}, ack);
    check(ack, 32'h0);
    foreach (b[i])
    begin
      host_u.writeByte(b[i], ack);
      check(ack, 32'h0);
    end
    host_u.stopCond();
  endtask

  task automatic fetch(input int n);
    host_u.startCond();
    host_u.writeByte({ADDR, 1'b1}, ack);
    check(ack, 32'h0);
    for (int i = 0; i < n; i++)
      host_u.readByte(i != n - 1, rx[i]);
    host_u.stopCond();
  endtask

  task automatic read_config_cmd(input logic [1:0] idx, input logic [7:0] exp);
    send('{{4'h2, idx, 2'h0}});
    fetch(1);
    check(rx[0], exp);
  endtask

  task automatic pulse(input logic [23:0] v);
    @(negedge clock);
    convResult = v;
    convDone = 1'b1;
    @(negedge clock);
    convDone = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  function automatic logic [15:0] crc16(input logic [23:0] d);
    logic [15:0] c;
    c = `ADCIF_CRC_INIT;
    for (int i = 23; i >= 0; i--)
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ `ADCIF_CRC_POLY) : {c[14:0], 1'b0};
    return c;
  endfunction

  initial
  begin
    repeat (100000) @(posedge clock);
    failCount++;
    finalReport();
  end

  initial
  begin
    rst = 1'b1;
    convDone = 1'b0;
    convResult = 24'h0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    for (int r = 0; r < 4; r++)
      read_config_cmd(r[1:0], 8'h00);
    send('{8'h40, 8'ha5, 8'h44, 8'h08, 8'h4c, 8'hff, 8'h48, 8'h0f});
    check({inputConfig, rateConfig, statusConfig, routeConfig}, 32'ha5080ffc);
    read_config_cmd(2'h0, 8'ha5);
    read_config_cmd(2'h3, 8'hfc);
    s0 = starts;
    send('{8'h08});
    send('{8'h09});
    check(starts - s0, 32'h2);
    pulse(24'h123456);
    check(readyPinOe, 32'h1);
    read_config_cmd(2'h2, 8'h8f);
    send('{8'h1f});
    fetch(3);
    check({rx[0], rx[1], rx[2]}, 32'h123456);
    check(readyPinOe, 32'h0);
    s0 = starts;
    send('{8'h40, 8'ha5});
    check(starts - s0, 32'h1);
    send('{8'h10});
    fork
      fetch(3);
      begin
        repeat (120) @(negedge clock);
        pulse(24'habcdef);
      end
    join
    check({rx[0], rx[1], rx[2]}, 32'h123456);
    check(readyPinOe, 32'h1);
    send('{8'h10});
    fetch(3);
    check({rx[0], rx[1], rx[2]}, 32'habcdef);
    send('{8'h48, 8'h5f});
    pulse(24'h807f01);
    send('{8'h10});
    fetch(8);
    check({rx[1], rx[2], rx[3]}, 32'h807f01);
    check(rx[0], 8'h03);
    for (int i = 0; i < 4; i++)
      check(rx[i + 4], 8'hff ^ rx[i]);
    send('{8'h10});
    fetch(8);
    check(rx[0], 8'h03);
    send('{8'h48, 8'h2f, 8'h10});
    fetch(5);
    check({rx[0], rx[1], rx[2]}, 32'h807f01);
    check({rx[3], rx[4]}, crc16(24'h807f01));
    s0 = starts;
    send('{8'hf0});
    check(starts - s0, 32'h0);
    check({inputConfig, rateConfig, statusConfig, routeConfig}, 32'ha5082ffc);
    send('{8'h07});
    read_config_cmd(2'h1, 8'h00);
    check({inputConfig, rateConfig, statusConfig, routeConfig}, 32'h0);
    check(analogOn, 32'h1);
    send('{8'h40, 8'h3c, 8'h02});
    check(analogOn, 32'h0);
    check(inputConfig, 32'h3c);
    s0 = starts;
    send('{8'h08});
    check(analogOn, 32'h1);
    send('{8'h08});
    check(starts - s0, 32'h2);
    send('{8'h03});
    check(analogOn, 32'h1);
    pulse(24'h000001);
    check(analogOn, 32'h0);
    finalReport();
  end
endmodule

bind adcif_decoder adcif_checker #(.RESULT_W(RESULT_W)) chk_u (
  .clock(clock), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .readyPinOut(readyPinOut), .readyPinOe(readyPinOe), .convDone(convDone),
  .convResult(convResult), .convStart(convStart), .analogOn(analogOn),
  .inputConfig(inputConfig), .rateConfig(rateConfig), .statusConfig(statusConfig),
  .routeConfig(routeConfig));
